// ==== design/uxt_pkg.sv ====
// Types shared by the transmitter top and the receiver
package uxt_pkg;

  typedef enum logic [1:0] {
    UXT_PAR_NONE = 2'b00,
    UXT_PAR_ZERO = 2'b01,
    UXT_PAR_ODD  = 2'b10,
    UXT_PAR_EVEN = 2'b11
  } uxt_par_t;

  typedef enum logic [2:0] {
    UXT_S_IDLE  = 3'b000,
    UXT_S_START = 3'b001,
    UXT_S_DATA  = 3'b010,
    UXT_S_PAR   = 3'b011,
    UXT_S_STOP  = 3'b100
  } uxt_st_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } uxt_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } uxt_apb_rsp_t;

  typedef struct packed {
    uxt_par_t par;
    logic     len8;
    logic     msb_first;
  } uxt_fmt_t;

  // Reverses the character so MSB-first data leaves bit 0 first
  function automatic logic [7:0] uxt_order(input logic [7:0] d,
                                           input logic len8,
                                           input logic msb);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) r[i] = d[7 - i];
    if (!msb) uxt_order = d;
    else if (len8) uxt_order = r;
    else uxt_order = {1'b0, r[7:1]};
  endfunction : uxt_order

endpackage : uxt_pkg

// ==== design/uxt_regs.svh ====
// Register map, field positions and reset values of the serial transmitter
//
// Overview of operation
// - Frame: start, 7/8 data, parity option, 1/2 stop
// - Control bit 1 selects LSB or MSB first
// - Control bit 0 inverts the serial output
// - Even mode sends one for odd ones count
// - Even mode receive errors on odd total
// - Odd mode sends zero for odd ones count
// - Odd mode receive errors on even total
// - Zero parity mode always sends zero
// - Zero parity mode never flags parity errors
// - No parity: no bit sent, none checked
// - Power enable clear holds output at idle high
// - Buffer write starts frame once transmit enabled
// - Frame start moves buffer into shift register
// - Done request right after final stop bit
// - Idle after frame until next buffer write
// - Buffer accepts data once shifting begins
// - Status bit 1 is buffer full
// - Status bit 0 is shift busy
// - Flags run 10, 01, 11; judge by full
// - Clearing transmit enable resets transmit circuitry
// - Receiver checks only one stop bit
`ifndef UXT_REGS_SVH
`define UXT_REGS_SVH

`define UXT_OFS_MODE     12'h000
`define UXT_OFS_CTRL     12'h004
`define UXT_OFS_STATUS   12'h008
`define UXT_OFS_TXBUF    12'h00c
`define UXT_OFS_DIV      12'h010
`define UXT_OFS_RXERR    12'h014
`define UXT_OFS_RXDATA   12'h018

`define UXT_MODE_RST     8'h01
`define UXT_CTRL_RST     2'h0
`define UXT_DIV_RST      16'h0010

`define UXT_B_POWER      7
`define UXT_B_TXEN       6
`define UXT_B_RXEN       5
`define UXT_B_PSH        4
`define UXT_B_PSL        3
`define UXT_B_LEN8       2
`define UXT_B_STOP2      1
`define UXT_B_DIR        1
`define UXT_B_INV        0
`define UXT_B_FULL       1
`define UXT_B_BUSY       0
`define UXT_B_PERR       2
`define UXT_B_FERR       1
`define UXT_B_OVR        0

`endif

// ==== design/uxt_rx.sv ====
// Serial receiver with parity check and single stop bit
`timescale 1ns/1ns
`include "uxt_regs.svh"
module uxt_rx #(
  parameter int DIV_W = 16
) (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                enable,
  input  wire logic [DIV_W-1:0]    div,
  input  wire uxt_pkg::uxt_fmt_t   fmt,
  input  wire logic                serial_input_pin,
  output logic [7:0]               rx_data,
  output logic                     rx_done,
  output logic                     rx_perr,
  output logic                     rx_ferr
);
  import uxt_pkg::*;

  typedef struct packed {
    uxt_st_t          st;
    logic [DIV_W-1:0] tick;
    logic [2:0]       cnt;
    logic [7:0]       sh;
    logic             ones;
    logic [7:0]       data;
    logic             done;
    logic             perr;
    logic             ferr;
  } uxt_rxs_t;

  uxt_rxs_t s;
  uxt_rxs_t next_s;
  logic     bit_end;
  logic     mid;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.perr = 1'b0;
    next_s.ferr = 1'b0;
    next_s.tick = s.tick + 1'b1;
    bit_end = (s.tick + 1'b1 >= div);
    mid = (s.tick + 1'b1 >= (div >> 1));
    case (s.st)
      UXT_S_IDLE: begin
        next_s.tick = '0;
        if (!serial_input_pin) next_s.st = UXT_S_START;
      end
      UXT_S_START: if (mid) begin
        next_s.tick = '0;
        next_s.cnt = '0;
        next_s.ones = 1'b0;
        next_s.st = serial_input_pin ? UXT_S_IDLE : UXT_S_DATA;
      end
      UXT_S_DATA: if (bit_end) begin
        next_s.tick = '0;
        next_s.cnt = s.cnt + 1'b1;
        next_s.ones = s.ones ^ serial_input_pin;
        next_s.sh = fmt.len8 ? {serial_input_pin, s.sh[7:1]}
                             : {1'b0, serial_input_pin, s.sh[6:1]};
        if (s.cnt == (fmt.len8 ? 3'h7 : 3'h6))
          next_s.st = (fmt.par == UXT_PAR_NONE) ? UXT_S_STOP : UXT_S_PAR;
      end
      UXT_S_PAR: if (bit_end) begin
        next_s.tick = '0;
        next_s.ones = s.ones ^ serial_input_pin;
        next_s.st = UXT_S_STOP;
      end
      UXT_S_STOP: if (bit_end) begin
        next_s.st = UXT_S_IDLE;
        next_s.done = 1'b1;
        next_s.ferr = !serial_input_pin;
        next_s.data = uxt_order(s.sh, fmt.len8, fmt.msb_first);
        // zero and none skip the check
        next_s.perr = (fmt.par == UXT_PAR_EVEN) ? s.ones :
                      (fmt.par == UXT_PAR_ODD) ? !s.ones : 1'b0;
      end
      default: next_s.st = UXT_S_IDLE;
    endcase
    if (!enable) begin
      next_s.st = UXT_S_IDLE;
      next_s.tick = '0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) s <= '0;
    else s <= next_s;
  end

  assign rx_data = s.data;
  assign rx_done = s.done;
  assign rx_perr = s.perr;
  assign rx_ferr = s.ferr;

endmodule : uxt_rx

// ==== design/uxt_top.sv ====
// Transmitter with frame formatting, APB registers and receiver parity check
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "uxt_regs.svh"
module uxt_top #(
  parameter int DIV_W = 16
) (
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  input  wire uxt_pkg::uxt_apb_req_t apb_req,
  output uxt_pkg::uxt_apb_rsp_t      apb_rsp,
  input  wire logic                  serial_input_pin,
  output logic                       serial_output_pin,
  output logic                       transmit_done_irq
);
  import uxt_pkg::*;

  // ************************************************************
  // Parameter check
  // ************************************************************
  if (DIV_W < 2 || DIV_W > 16) begin : g_chk
    $error("DIV_W must lie in 2..16");
  end

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0]       mode;
    logic [1:0]       ctrl;
    logic [DIV_W-1:0] div;
    logic [7:0]       txbuf;
    logic             full;
    logic             busy;
    uxt_st_t          st;
    logic [7:0]       shreg;
    logic             par;
    logic [2:0]       cnt;
    logic             stop_n;
    logic [DIV_W-1:0] tick;
    logic             line;
    logic             irq;
    logic [2:0]       rxerr;
    logic [7:0]       rxdata;
    logic [31:0]      prdata;
  } uxt_state_t;

  uxt_state_t s;
  uxt_state_t next_s;

  logic       power;
  logic       tx_on;
  uxt_fmt_t   fmt;
  logic       stop2;
  logic       bit_end;
  logic       load;
  logic       sel_ok;
  logic       wr;
  logic       rd;
  logic       setup;
  logic [7:0] ones_src;
  logic [7:0] rx_data;
  logic       rx_done;
  logic       rx_perr;
  logic       rx_ferr;

  assign power = s.mode[`UXT_B_POWER];
  assign tx_on = power & s.mode[`UXT_B_TXEN];
  assign stop2 = s.mode[`UXT_B_STOP2];
  assign fmt.par = uxt_par_t'(s.mode[`UXT_B_PSH:`UXT_B_PSL]);
  assign fmt.len8 = s.mode[`UXT_B_LEN8];
  assign fmt.msb_first = s.ctrl[`UXT_B_DIR];

  // ************************************************************
  // Bus decode
  // ************************************************************
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `UXT_OFS_MODE) || (a == `UXT_OFS_CTRL) ||
             (a == `UXT_OFS_STATUS) || (a == `UXT_OFS_TXBUF) ||
             (a == `UXT_OFS_DIV) || (a == `UXT_OFS_RXERR) ||
             (a == `UXT_OFS_RXDATA);
  endfunction : mapped

  assign sel_ok = mapped(apb_req.paddr);
  assign setup = apb_req.psel & ~apb_req.penable;
  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite & sel_ok;
  assign rd = apb_req.psel & apb_req.penable & ~apb_req.pwrite & sel_ok;

  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~sel_ok;
  assign apb_rsp.prdata = s.prdata;

  // ************************************************************
  // Receiver
  // ************************************************************
  uxt_rx #(
    .DIV_W (DIV_W)
  ) u_rx (
    .core_clk         (core_clk),
    .resetn           (resetn),
    .enable           (power & s.mode[`UXT_B_RXEN]),
    .div              (s.div),
    .fmt              (fmt),
    .serial_input_pin (serial_input_pin | ~power),
    .rx_data          (rx_data),
    .rx_done          (rx_done),
    .rx_perr          (rx_perr),
    .rx_ferr          (rx_ferr)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_s = s;
    next_s.irq = 1'b0;
    next_s.tick = s.tick + 1'b1;
    bit_end = (s.tick + 1'b1 >= s.div);
    load = 1'b0;
    ones_src = fmt.len8 ? s.txbuf : {1'b0, s.txbuf[6:0]};

    // Read data is captured in the setup phase
    if (setup) begin
      case (apb_req.paddr)
        `UXT_OFS_MODE:   next_s.prdata = {24'h0, s.mode};
        `UXT_OFS_CTRL:   next_s.prdata = {30'h0, s.ctrl};
        // full at bit 1, busy at bit 0
        `UXT_OFS_STATUS: next_s.prdata = {30'h0, s.full, s.busy};
        `UXT_OFS_DIV:    next_s.prdata = 32'(s.div);
        `UXT_OFS_RXERR:  next_s.prdata = {29'h0, s.rxerr};
        `UXT_OFS_RXDATA: next_s.prdata = {24'h0, s.rxdata};
        default:         next_s.prdata = 32'h0;
      endcase
    end

    // Transmit sequencer
    case (s.st)
      UXT_S_IDLE: begin
        next_s.tick = '0;
        // stays idle until buffer holds data
        if (s.full) load = 1'b1;
      end
      UXT_S_START: if (bit_end) begin
        next_s.tick = '0;
        next_s.cnt = '0;
        next_s.st = UXT_S_DATA;
      end
      UXT_S_DATA: if (bit_end) begin
        next_s.tick = '0;
        next_s.cnt = s.cnt + 1'b1;
        next_s.shreg = {1'b0, s.shreg[7:1]};
        // seven or eight bits, parity optional
        if (s.cnt == (fmt.len8 ? 3'h7 : 3'h6))
          next_s.st = (fmt.par == UXT_PAR_NONE) ? UXT_S_STOP : UXT_S_PAR;
        next_s.stop_n = 1'b0;
      end
      UXT_S_PAR: if (bit_end) begin
        next_s.tick = '0;
        next_s.st = UXT_S_STOP;
      end
      UXT_S_STOP: if (bit_end) begin
        next_s.tick = '0;
        if (stop2 && !s.stop_n) begin
          next_s.stop_n = 1'b1;
        end else begin
          // done request after last stop bit
          next_s.irq = 1'b1;
          // busy clears only with buffer empty
          next_s.busy = 1'b0;
          next_s.st = UXT_S_IDLE;
          if (s.full) load = 1'b1;
        end
      end
      default: next_s.st = UXT_S_IDLE;
    endcase

    // buffer moves into the shift register
    if (load) begin
      next_s.st = UXT_S_START;
      next_s.tick = '0;
      next_s.busy = 1'b1;
      next_s.full = 1'b0;
      next_s.shreg = uxt_order(s.txbuf, fmt.len8, fmt.msb_first);
      case (fmt.par)
        UXT_PAR_EVEN: next_s.par = ^ones_src;
        UXT_PAR_ODD:  next_s.par = ~(^ones_src);
        default:      next_s.par = 1'b0;
      endcase
    end

    // Register writes
    if (wr) begin
      case (apb_req.paddr)
        `UXT_OFS_MODE: next_s.mode = apb_req.pwdata[7:0];
        `UXT_OFS_CTRL: next_s.ctrl = apb_req.pwdata[1:0];
        `UXT_OFS_DIV:  next_s.div = apb_req.pwdata[DIV_W-1:0];
        `UXT_OFS_TXBUF: begin
          // write starts a frame when enabled
          // full set here, full and busy read 11 mid-frame
          if (tx_on) begin
            next_s.txbuf = apb_req.pwdata[7:0];
            next_s.full = 1'b1;
          end
        end
        default: next_s.mode = next_s.mode;
      endcase
    end

    // Receive error flags: set wins over clear on read
    if (rd && apb_req.paddr == `UXT_OFS_RXERR) next_s.rxerr = 3'h0;
    if (rx_done) begin
      next_s.rxdata = rx_data;
      next_s.rxerr[`UXT_B_PERR] = next_s.rxerr[`UXT_B_PERR] | rx_perr;
      next_s.rxerr[`UXT_B_FERR] = next_s.rxerr[`UXT_B_FERR] | rx_ferr;
    end
    if (!power) next_s.rxerr = 3'h0;

    // transmit disable resets the transmit circuit
    if (!tx_on) begin
      next_s.st = UXT_S_IDLE;
      next_s.full = 1'b0;
      next_s.busy = 1'b0;
      next_s.tick = '0;
      next_s.irq = 1'b0;
    end

    // Line level follows the next state
    case (next_s.st)
      UXT_S_START: next_s.line = 1'b0;
      UXT_S_DATA:  next_s.line = next_s.shreg[0];
      UXT_S_PAR:   next_s.line = next_s.par;
      default:     next_s.line = 1'b1;
    endcase
    // output held high with power clear
    if (!power) next_s.line = 1'b1;
    else next_s.line = next_s.line ^ s.ctrl[`UXT_B_INV];
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.mode <= `UXT_MODE_RST;
      s.ctrl <= `UXT_CTRL_RST;
      s.div <= DIV_W'(`UXT_DIV_RST);
      s.line <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign serial_output_pin = s.line;
  assign transmit_done_irq = s.irq;

endmodule : uxt_top

// ==== testbench/uxt_remote_node.sv ====
// Remote serial node: samples transmitted frames and sends frames back
`timescale 1ns/1ns
module uxt_remote_node (
  input  wire logic        core_clk,
  input  wire logic        arm,
  input  wire logic        inv,
  input  wire logic [31:0] div,
  input  wire logic [31:0] nbits,
  input  wire logic        line_in,
  output logic             line_out
);
  logic [11:0] frame;
  int          frames;
  initial begin
    line_out = 1'b1;
    frame = '1;
    frames = 0;
    forever begin
      @(posedge core_clk);
      if (arm && (line_in ^ inv) === 1'b0) begin
        frame = '1;
        repeat (div / 2) @(posedge core_clk);
        for (int i = 0; i < nbits; i++) begin
          repeat (div) @(posedge core_clk);
          frame[i] = line_in ^ inv;
        end
        frames++;
      end
    end
  end
  task automatic send(input logic [11:0] b, input int n);
    line_out <= 1'b0;
    repeat (div) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      line_out <= b[i];
      repeat (div) @(posedge core_clk);
    end
    line_out <= 1'b1;
  endtask : send
endmodule : uxt_remote_node

// ==== testbench/uxt_top_assertions.sv ====
// Port-level concurrent checks for the serial transmitter top
`timescale 1ns/1ns
module uxt_chk (
  input wire logic                  core_clk,
  input wire logic                  resetn,
  input wire uxt_pkg::uxt_apb_req_t apb_req,
  input wire uxt_pkg::uxt_apb_rsp_t apb_rsp,
  input wire logic                  serial_input_pin,
  input wire logic                  serial_output_pin,
  input wire logic                  transmit_done_irq
);
  import uxt_pkg::*;
  logic       acc;
  logic       rd_st;
  logic [7:0] mode_q;
  assign acc   = apb_req.psel && apb_req.penable;
  assign rd_st = acc && !apb_req.pwrite && apb_req.paddr == 12'h008;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ****
  // Shadow of the mode register
  // ****
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) mode_q <= 8'h01;
    else if (acc && apb_req.pwrite && apb_req.paddr == 12'h000) mode_q <= apb_req.pwdata[7:0];
  end
  pready_high_a: assert property (acc |-> apb_rsp.pready)
    else $error("pready low in access phase");
  slverr_phase_a: assert property (apb_rsp.pslverr |-> acc)
    else $error("pslverr outside access phase");
  unmapped_err_a: assert property (acc && apb_req.paddr > 12'h018 |-> apb_rsp.pslverr)
    else $error("unmapped access without pslverr");
  unmapped_zero_a: assert property (acc && !apb_req.pwrite && apb_req.paddr > 12'h018
    |-> apb_rsp.prdata == 32'h0)
    else $error("unmapped read not zero");
  irq_spacing_a: assert property (transmit_done_irq |=> !transmit_done_irq [*8])
    else $error("done pulse too long or too close");
  status_upper_a: assert property (rd_st |-> apb_rsp.prdata[31:2] == 30'h0)
    else $error("status upper bits not zero");
  power_idle_a: assert property (!mode_q[7] [*2] |-> serial_output_pin)
    else $error("output not high with power off");
  txoff_status_a: assert property (!mode_q[6] [*3] ##0 rd_st
    |-> apb_rsp.prdata[1:0] == 2'b00)
    else $error("status flags set with transmit disabled");
  txoff_irq_a: assert property (!mode_q[6] [*3] |-> !transmit_done_irq)
    else $error("done pulse with transmit disabled");
  cover property (transmit_done_irq);
  cover property (apb_rsp.pslverr);
  cover property (rd_st && apb_rsp.prdata[1:0] == 2'b01);
endmodule : uxt_chk

// ==== testbench/uxt_top_tb_top.sv ====
// Self-checking bench for the serial transmitter top
`timescale 1ns/1ns
module uxt_top_tb_top;
  import uxt_pkg::*;
  logic         core_clk;
  logic         resetn;
  uxt_apb_req_t req;
  uxt_apb_rsp_t rsp;
  logic         rx_line;
  logic         tx_line;
  logic         irq;
  logic         arm;
  logic         inv;
  int           nbits;
  int           failures;
  int           cmp_count;
  int           irqs;
  logic [31:0]  rdat;
  logic         rerr;
  logic [11:0]  ra [5] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h01c};
  logic [31:0]  rv [5] = '{32'h1, 32'h0, 32'h0, 32'h10, 32'h0};

  uxt_top dut_u (.core_clk(core_clk), .resetn(resetn), .apb_req(req), .apb_rsp(rsp),
    .serial_input_pin(rx_line), .serial_output_pin(tx_line), .transmit_done_irq(irq));
  uxt_remote_node rm (.core_clk(core_clk), .arm(arm), .inv(inv), .div(8), .nbits(nbits),
    .line_in(tx_line), .line_out(rx_line));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (irq === 1'b1) irqs <= irqs + 1;

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int t;
    req <= '{1'b1, 1'b0, w, a, wd};
    @(posedge core_clk);
    req.penable <= 1'b1;
    t = 0;
    do begin
      @(posedge core_clk);
      t++;
    end while (rsp.pready !== 1'b1 && t < 50);
    if (rsp.pready !== 1'b1) failures++;
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic wait_frames(input int n);
    int t;
    t = 0;
    while (rm.frames < n && t < 3000) begin
      @(posedge core_clk);
      t++;
    end
    if (t >= 3000) failures++;
  endtask : wait_frames

  task automatic cfg(input logic [1:0] p, input logic l8, input logic s2, input logic msb,
                     input logic iv);
    arm <= 1'b0;
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, {30'h0, msb, iv});
    apb(1'b1, 12'h010, 32'h8);
    apb(1'b1, 12'h000, {24'h0, 3'b111, p, l8, s2, 1'b0});
    inv <= iv;
    nbits <= (l8 ? 8 : 7) + int'(p != 2'b00) + 1 + int'(s2);
    repeat (3) @(posedge core_clk);
    arm <= 1'b1;
  endtask : cfg

  function automatic logic [11:0] tx_bits(input logic [7:0] d, input logic [1:0] p,
                                          input logic l8, input logic msb);
    logic [11:0] b;
    int          n;
    logic        q;
    b = '1;
    n = l8 ? 8 : 7;
    q = ^(d & (l8 ? 8'hff : 8'h7f));
    for (int i = 0; i < n; i++) b[i] = msb ? d[n - 1 - i] : d[i];
    if (p != UXT_PAR_NONE) b[n] = (p == UXT_PAR_EVEN) ? q : (p == UXT_PAR_ODD) ? ~q : 1'b0;
    return b;
  endfunction : tx_bits

  initial begin
    repeat (40000) @(posedge core_clk);
    failures++;
    print_verdict();
  end

  initial begin
    logic [7:0] d;
    logic [1:0] p;
    logic [3:0] o;
    int         k;
    int         n0;
    req = '0;
    resetn = 1'b0;
    arm = 1'b0;
    inv = 1'b0;
    nbits = 9;
    irqs = 0;
    void'($urandom(32'hbd30d31f));
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    for (k = 0; k < 5; k++) begin
      apb(1'b0, ra[k], 32'h0);
      chk("reset value", rdat, rv[k]);
      chk("slave error", {31'h0, rerr}, {31'h0, k == 4});
    end
    $display("done: reset values");
    for (k = 0; k < 12; k++) begin
      o = 4'($urandom);
      d = (k == 0) ? 8'h55 : 8'($urandom);
      p = 2'(k);
      cfg(p, o[3], o[2], o[1], o[0]);
      chk("idle level", {31'h0, tx_line}, {31'h0, ~o[0]});
      n0 = irqs;
      apb(1'b1, 12'h00c, {24'h0, d});
      wait_frames(rm.frames + 1);
      chk("frame bits", {20'h0, rm.frame}, {20'h0, tx_bits(d, p, o[3], o[1])});
      repeat (8) @(posedge core_clk);
      apb(1'b0, 12'h008, 32'h0);
      // status reads zero before next write
      chk("status idle", rdat, 32'h0);
      chk("done pulses", 32'(irqs), 32'(n0 + 1));
    end
    $display("done: single frames");
    cfg(UXT_PAR_EVEN, 1'b1, 1'b0, 1'b0, 1'b0);
    n0 = rm.frames;
    apb(1'b1, 12'h00c, 32'ha5);
    k = 0;
    do begin
      apb(1'b0, 12'h008, 32'h0);
      k++;
    end while (rdat[1] !== 1'b0 && k < 100);
    chk("flags while shifting", rdat, 32'h1);
    apb(1'b1, 12'h00c, 32'h3c);
    apb(1'b0, 12'h008, 32'h0);
    chk("flags both set", rdat, 32'h3);
    wait_frames(n0 + 1);
    chk("first of pair", {20'h0, rm.frame}, {20'h0, tx_bits(8'ha5, p, 1'b1, 1'b0)});
    wait_frames(n0 + 2);
    chk("second of pair", {20'h0, rm.frame}, {20'h0, tx_bits(8'h3c, p, 1'b1, 1'b0)});
    // wait for done, then busy reads zero
    repeat (8) @(posedge core_clk);
    apb(1'b0, 12'h008, 32'h0);
    chk("busy after pair", rdat, 32'h0);
    $display("done: back to back");
    n0 = irqs;
    apb(1'b1, 12'h00c, 32'hf0);
    repeat (20) @(posedge core_clk);
    apb(1'b1, 12'h000, 32'h98);
    apb(1'b0, 12'h008, 32'h0);
    chk("status after disable", rdat, 32'h0);
    chk("line after disable", {31'h0, tx_line}, 32'h1);
    apb(1'b1, 12'h00c, 32'h0f);
    apb(1'b0, 12'h008, 32'h0);
    chk("write while disabled", rdat, 32'h0);
    chk("no done pulse", 32'(irqs), 32'(n0));
    $display("done: disable mid frame");
    for (k = 0; k < 8; k++) begin
      p = 2'(k);
      d = 8'($urandom);
      o = 4'($urandom);
      cfg(p, o[3], o[2], o[1], 1'b0);
      b_send(d, p, o, k >= 4);
      apb(1'b0, 12'h014, 32'h0);
      chk("parity error", {31'h0, rdat[2]}, {31'h0, k >= 4 && p[1]});
      apb(1'b0, 12'h018, 32'h0);
      chk("received char", {24'h0, rdat[7:0]}, {24'h0, o[3] ? d : {1'b0, d[6:0]}});
    end
    $display("done: receive parity");
    print_verdict();
  end

  task automatic b_send(input logic [7:0] d, input logic [1:0] p, input logic [3:0] o,
                        input logic bad);
    logic [11:0] b;
    b = tx_bits(d, p, o[3], o[1]);
    if (bad && p != UXT_PAR_NONE) b[o[3] ? 8 : 7] = ~b[o[3] ? 8 : 7];
    rm.send(b, (o[3] ? 8 : 7) + int'(p != 2'b00) + 1);
    repeat (8) @(posedge core_clk);
  endtask : b_send
endmodule : uxt_top_tb_top

bind uxt_top uxt_chk chk_u (.core_clk(core_clk), .resetn(resetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .serial_input_pin(serial_input_pin),
  .serial_output_pin(serial_output_pin), .transmit_done_irq(transmit_done_irq));
